// ===== design/nbbm_defs.svh
/*
 * Constants for the bad-block handling logic of the flash array.
 * Assumes it is included by bare name from the design files; the package does not include it.
 */
`ifndef NBBM_DEFS_SVH
`define NBBM_DEFS_SVH

// ****************************************************************
// Array geometry
// ****************************************************************
`define NBBM_BLOCKS      4096
`define NBBM_MIN_GOOD    4016
`define NBBM_PAGES       64
`define NBBM_MAIN_BYTES  2048
`define NBBM_PAGE_BYTES  2112

// ****************************************************************
// Marker layout and values
// ****************************************************************
`define NBBM_MARK_PAGES  2
`define NBBM_MARK_BYTE   8'h00
`define NBBM_ERASED_BYTE 8'hFF
`define NBBM_BOOT_BLOCK  0

`endif

// ===== design/nbbm_marker_table.sv
/*
 * Per-block factory defect marker storage, one flip-flop per block.
 * Assumes clear requests come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "nbbm_defs.svh"

module nbbm_marker_table #(
  parameter int                BLOCKS      = `NBBM_BLOCKS,
  parameter int                BW          = $clog2(`NBBM_BLOCKS),
  parameter logic [BLOCKS-1:0] FACTORY_BAD = '0
) (
  // Clock, reset and enable
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // Lookup
  input  wire logic [BW-1:0] rd_idx,
  output logic               rd_marker,
  // Marker loss on erase
  input  wire logic          clr_en,
  input  wire logic [BW-1:0] clr_idx
);

  localparam logic [BLOCKS-1:0] BOOT_MASK =
    ~({{(BLOCKS-1){1'b0}}, 1'b1} << `NBBM_BOOT_BLOCK);

  logic [BLOCKS-1:0] mark_q;
  logic [BLOCKS-1:0] mark_d;

  always_comb begin
    mark_d = mark_q;
    if (clr_en) begin
      mark_d[clr_idx] = 1'b0;
    end
  end

  // Markers start as shipped; the boot block can never carry one.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mark_q <= FACTORY_BAD & BOOT_MASK;
    end else if (ce) begin
      mark_q <= mark_d;
    end
  end

  assign rd_marker = mark_q[rd_idx];

endmodule // nbbm_marker_table
`default_nettype wire

// ===== design/nbbm_pkg.sv
/*
 * Types shared by the bad-block handling logic.
 * Assumes nbbm_defs.svh is on the include path.
 */
`default_nettype none
package nbbm_pkg;

  typedef enum logic [1:0] {
    NBBM_OP_READ,
    NBBM_OP_PROG,
    NBBM_OP_ERASE
  } nbbm_op_t;

  typedef enum logic [1:0] {
    NBBM_ST_SCAN,
    NBBM_ST_IDLE,
    NBBM_ST_WAIT
  } nbbm_state_t;

endpackage
`default_nettype wire

// ===== design/nbbm_top.sv
/*
 * Bad-block handling in front of the flash cell array: factory marker
 * readout, isolation of defective blocks and the good-block census.
 * Assumes the array core and the command front end share core_clk.
 */
// Notes on behaviour
// - Block zero is always good and never reads back a defect marker.
// - At least the minimum count of all blocks is good, checked at start.
// - A defective block shows a non-all-ones first spare byte in page 0/1 until it is erased.
// - A defective block is cut off from the array and cannot disturb it.
`timescale 1ns/100ps
`default_nettype none
`include "nbbm_defs.svh"

module nbbm_top
  import nbbm_pkg::*;
#(
  parameter int                BLOCKS      = `NBBM_BLOCKS,
  parameter int                MIN_GOOD    = `NBBM_MIN_GOOD,
  parameter int                PAGES       = `NBBM_PAGES,
  parameter int                PAGE_BYTES  = `NBBM_PAGE_BYTES,
  parameter int                MAIN_BYTES  = `NBBM_MAIN_BYTES,
  parameter logic [BLOCKS-1:0] FACTORY_BAD = '0,
  parameter int                BW          = $clog2(BLOCKS),
  parameter int                PW          = $clog2(PAGES),
  parameter int                CW          = $clog2(PAGE_BYTES)
) (
  // Clock, reset and enable
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // Operation request
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire nbbm_op_t      req_op,
  input  wire logic [BW-1:0] req_block,
  input  wire logic [PW-1:0] req_page,
  input  wire logic [CW-1:0] req_col,
  // Operation result
  output logic               rsp_valid,
  output logic               rsp_fail,
  output logic [7:0]         rsp_data,
  // Cell array core
  output logic               arr_start,
  output nbbm_op_t           arr_op,
  output logic [BW-1:0]      arr_block,
  output logic [PW-1:0]      arr_page,
  output logic [CW-1:0]      arr_col,
  input  wire logic [7:0]    arr_rdata,
  input  wire logic          arr_done,
  input  wire logic          arr_fail,
  // Census
  output logic               scan_done,
  output logic [BW:0]        good_count,
  output logic               good_ok
);

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam logic [BW-1:0] LAST_BLK  = BW'(BLOCKS - 1);
  localparam logic [BW:0]   MIN_CNT   = (BW + 1)'(MIN_GOOD);
  localparam logic [PW-1:0] MARK_PGS  = PW'(`NBBM_MARK_PAGES);
  localparam logic [CW-1:0] MARK_COL  = CW'(MAIN_BYTES);

  // ****************************************************************
  // State
  // ****************************************************************
  nbbm_state_t   st_q, st_d;
  nbbm_op_t      op_q, op_d;
  logic [BW-1:0] blk_q, blk_d;
  logic [PW-1:0] pg_q, pg_d;
  logic [CW-1:0] col_q, col_d;
  logic [BW-1:0] scan_q, scan_d;
  logic [BW:0]   cnt_q, cnt_d;
  logic          done_q, done_d;
  logic          ok_q, ok_d;
  logic          start_q, start_d;
  logic          rv_q, rv_d;
  logic          rf_q, rf_d;
  logic [7:0]    rd_q, rd_d;

  logic [BW-1:0] look_idx;
  logic          look_mark;
  logic          look_iso;
  logic          clr_en;
  logic          accept;
  logic          at_mark;

  // ****************************************************************
  // Defect lookup
  // ****************************************************************
  // Isolation follows the factory map and is never lifted, so a block
  // whose marker was erased away still stays cut off from the array.
  assign look_idx = (st_q == NBBM_ST_SCAN) ? scan_q : req_block;
  assign look_iso = FACTORY_BAD[look_idx] &&
                    (look_idx != BW'(`NBBM_BOOT_BLOCK));

  nbbm_marker_table #(
    .BLOCKS      (BLOCKS),
    .BW          (BW),
    .FACTORY_BAD (FACTORY_BAD)
  ) u_table (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .rd_idx    (look_idx),
    .rd_marker (look_mark),
    .clr_en    (clr_en),
    .clr_idx   (req_block)
  );

  assign req_ready = ce && (st_q == NBBM_ST_IDLE);
  assign accept    = req_ready && req_valid;
  assign at_mark   = (req_page < MARK_PGS) && (req_col == MARK_COL);
  // Erasing a defective block wipes its marker until the next reset.
  assign clr_en    = accept && (req_op == NBBM_OP_ERASE) && look_iso;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    blk_d   = blk_q;
    pg_d    = pg_q;
    col_d   = col_q;
    scan_d  = scan_q;
    cnt_d   = cnt_q;
    done_d  = done_q;
    ok_d    = ok_q;
    start_d = 1'b0;
    rv_d    = 1'b0;
    rf_d    = rf_q;
    rd_d    = rd_q;
    case (st_q)
      NBBM_ST_SCAN: begin
        // One block per cycle; requests wait until the census is in.
        if (!look_iso) begin
          cnt_d = cnt_q + (BW + 1)'(1);
        end
        if (scan_q == LAST_BLK) begin
          done_d = 1'b1;
          ok_d   = (cnt_d >= MIN_CNT);
          st_d   = NBBM_ST_IDLE;
        end else begin
          scan_d = scan_q + BW'(1);
        end
      end
      NBBM_ST_IDLE: begin
        if (accept) begin
          op_d  = req_op;
          blk_d = req_block;
          pg_d  = req_page;
          col_d = req_col;
          if (look_iso) begin
            // Answer locally; the array never sees this block.
            rv_d = 1'b1;
            rf_d = (req_op != NBBM_OP_READ);
            if (req_op == NBBM_OP_READ && look_mark && at_mark) begin
              rd_d = `NBBM_MARK_BYTE;
            end else begin
              rd_d = `NBBM_ERASED_BYTE;
            end
          end else begin
            start_d = 1'b1;
            st_d    = NBBM_ST_WAIT;
          end
        end
      end
      NBBM_ST_WAIT: begin
        if (arr_done) begin
          rv_d = 1'b1;
          rf_d = (op_q != NBBM_OP_READ) && arr_fail;
          rd_d = (op_q == NBBM_OP_READ) ? arr_rdata : `NBBM_ERASED_BYTE;
          st_d = NBBM_ST_IDLE;
        end
      end
      default: begin
        st_d = NBBM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q    <= NBBM_ST_SCAN;
      op_q    <= NBBM_OP_READ;
      blk_q   <= '0;
      pg_q    <= '0;
      col_q   <= '0;
      scan_q  <= '0;
      cnt_q   <= '0;
      done_q  <= 1'b0;
      ok_q    <= 1'b0;
      start_q <= 1'b0;
      rv_q    <= 1'b0;
      rf_q    <= 1'b0;
      rd_q    <= `NBBM_ERASED_BYTE;
    end else if (ce) begin
      st_q    <= st_d;
      op_q    <= op_d;
      blk_q   <= blk_d;
      pg_q    <= pg_d;
      col_q   <= col_d;
      scan_q  <= scan_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
      ok_q    <= ok_d;
      start_q <= start_d;
      rv_q    <= rv_d;
      rf_q    <= rf_d;
      rd_q    <= rd_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rsp_valid  = rv_q;
  assign rsp_fail   = rf_q;
  assign rsp_data   = rd_q;
  assign arr_start  = start_q;
  assign arr_op     = op_q;
  assign arr_block  = blk_q;
  assign arr_page   = pg_q;
  assign arr_col    = col_q;
  assign scan_done  = done_q;
  assign good_count = cnt_q;
  assign good_ok    = ok_q;

endmodule // nbbm_top
`default_nettype wire

// ===== sim/nbbm_array_model.sv
/* Behavioural cell array core answering nbbm_top.
   Assumes one request at a time and a failure flag set by the bench. */
`timescale 1ns/100ps
`default_nettype none
module nbbm_array_model #(
  parameter int BW = 4
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Command
  input  wire logic          arr_start,
  input  wire logic [BW-1:0] arr_block,
  input  wire logic [5:0]    arr_page,
  input  wire logic [11:0]   arr_col,
  input  wire logic          fail_next,
  // Answer
  output logic [7:0]         arr_rdata = 8'h5A,
  output logic               arr_done = 1'b0,
  output logic               arr_fail = 1'b0
);
  logic [1:0] wait_q;
  logic       busy_q;
  logic       fail_q;
  logic [7:0] byte_q;
  // Latency follows the block number so both prompt and slow answers occur.
  always @(posedge core_clk) begin
    arr_done  <= 1'b0;
    arr_rdata <= ~arr_rdata;
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (arr_start) begin
      busy_q <= 1'b1;
      wait_q <= arr_block[1:0];
      fail_q <= fail_next;
      // Spare columns stay erased; only main-area bytes carry a pattern.
      byte_q <= arr_col[11] ? 8'hFF :
                8'(arr_block) ^ {arr_page[3:0], 4'h0} ^ arr_col[7:0];
    end else if (busy_q && wait_q == 2'h0) begin
      busy_q    <= 1'b0;
      arr_done  <= 1'b1;
      arr_fail  <= fail_q;
      arr_rdata <= byte_q;
    end else if (busy_q) begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule // nbbm_array_model
`default_nettype wire

// ===== sim/nbbm_top_props.sv
/* Port assertions for nbbm_top.
   Assumes it is bound into nbbm_top and shares its parameters. */
`timescale 1ns/100ps
`default_nettype none
module nbbm_top_props
  import nbbm_pkg::*;
#(
  parameter int                BLOCKS      = 16,
  parameter int                MIN_GOOD    = 12,
  parameter int                BW          = 4,
  parameter logic [BLOCKS-1:0] FACTORY_BAD = '0
) (
  // Clock and control
  input wire logic          core_clk,
  input wire logic          rst_n,
  input wire logic          ce,
  // Requests
  input wire logic          req_valid,
  input wire logic          req_ready,
  input wire nbbm_op_t      req_op,
  input wire logic [BW-1:0] req_block,
  // Results and array
  input wire logic          rsp_valid,
  input wire logic          rsp_fail,
  input wire logic          arr_start,
  input wire logic          arr_done,
  // Census
  input wire logic          scan_done,
  input wire logic [BW:0]   good_count,
  input wire logic          good_ok
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic iso;
  assign take = req_valid && req_ready;
  assign iso  = FACTORY_BAD[req_block] && (req_block != 0);

  chk_boot_block_good: assert property (take && req_block == 0 |=> arr_start)
    else $error("block zero not sent to array");
  chk_census_flag: assert property (scan_done |-> good_ok == (good_count >= MIN_GOOD))
    else $error("census flag disagrees with count");
  chk_census_held: assert property ($rose(scan_done) |=> scan_done [*8])
    else $error("census done dropped");
  chk_iso_cut_off: assert property (take && iso |=> rsp_valid && !arr_start)
    else $error("isolated block reached array");
  chk_iso_pe_fail: assert property (take && iso && req_op != NBBM_OP_READ |=> rsp_fail)
    else $error("isolated program or erase not failed");
  chk_good_start: assert property (take && !iso |=> arr_start ##1 !arr_start)
    else $error("array start not a single pulse");
  chk_done_answer: assert property (arr_done && ce |=> rsp_valid)
    else $error("no answer after array done");
  chk_frozen_busy: assert property (!ce |-> !req_ready)
    else $error("ready while clock enable low");

  cover property (take && iso);
  cover property (take && !iso && req_op == NBBM_OP_ERASE);
  cover property (rsp_valid && rsp_fail);
endmodule // nbbm_top_props

bind nbbm_top nbbm_top_props #(.BLOCKS(BLOCKS), .MIN_GOOD(MIN_GOOD), .BW(BW),
  .FACTORY_BAD(FACTORY_BAD)) nbbm_top_props_i (.core_clk, .rst_n, .ce,
  .req_valid, .req_ready, .req_op, .req_block, .rsp_valid, .rsp_fail,
  .arr_start, .arr_done, .scan_done, .good_count, .good_ok);
`default_nettype wire

// ===== sim/nbbm_top_test.sv
/* Self-checking bench for nbbm_top with a 16-block array.
   Assumes the array model file and the checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`define CMP(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module nbbm_top_test;
  import nbbm_pkg::*;
  localparam logic [15:0] BAD = 16'h0025;
  logic core_clk = 0, rst_n = 0, ce = 1, req_valid = 0, fail_next = 0;
  nbbm_op_t req_op = NBBM_OP_READ, arr_op, o;
  logic [3:0] req_block = '0, arr_block;
  logic [5:0] req_page = '0, arr_page;
  logic [11:0] req_col = '0, arr_col;
  logic req_ready, rsp_valid, rsp_fail, arr_start, arr_done, arr_fail;
  logic scan_done, good_ok, f;
  logic [7:0] rsp_data, arr_rdata;
  logic [4:0] good_count;
  logic [15:0] wiped = '0, bbt = '0;
  logic [23:0] cmd_sent, cmd_seen;
  int fail_count = 0, checks = 0, cyc = 0, seed = 69206, b, pg[16];
  int r, n, retired = 0;

  nbbm_top #(.BLOCKS(16), .MIN_GOOD(12), .FACTORY_BAD(BAD), .BW(4))
    nbbm_top_i (.core_clk, .rst_n, .ce, .req_valid, .req_ready, .req_op,
    .req_block, .req_page, .req_col, .rsp_valid, .rsp_fail, .rsp_data,
    .arr_start, .arr_op, .arr_block, .arr_page, .arr_col, .arr_rdata,
    .arr_done, .arr_fail, .scan_done, .good_count, .good_ok);
  nbbm_array_model #(.BW(4)) nbbm_array_model_i (.core_clk, .rst_n,
    .arr_start, .arr_block, .arr_page, .arr_col, .fail_next, .arr_rdata,
    .arr_done, .arr_fail);

  always #25 core_clk = ~core_clk;
  assign cmd_sent = {req_op, req_block, req_page, req_col};
  assign cmd_seen = {arr_op, arr_block, arr_page, arr_col};
  // The request stays on the bench's pins until its answer, so the
  // command passed to the array can be held against it.
  always @(negedge core_clk) begin
    if (arr_start) `CMP("arr_cmd", cmd_sent, cmd_seen)
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  function automatic logic [7:0] want(int b, int p, int c);
    if (BAD[b] && b != 0)
      return (c == 2048 && p < 2 && !wiped[b]) ? 8'h00 : 8'hFF;
    if (c >= 2048) return 8'hFF;
    return 8'(b) ^ 8'(p << 4) ^ 8'(c);
  endfunction

  task automatic op(nbbm_op_t o, int b, int p, int c, logic f);
    @(negedge core_clk);
    req_op = o; req_block = 4'(b); req_page = 6'(p); req_col = 12'(c);
    fail_next = f;
    req_valid = 1;
    while (!req_ready) @(negedge core_clk);
    @(negedge core_clk);
    req_valid = 0;
    while (!rsp_valid) @(negedge core_clk);
  endtask

  initial begin
    repeat (3) @(negedge core_clk);
    rst_n = 1;
    while (!scan_done) @(negedge core_clk);
    `CMP("good_count", 5'd14, good_count)
    `CMP("good_ok", 1'b1, good_ok)
    ce = 0;
    #1 `CMP("req_ready", 1'b0, req_ready)
    ce = 1;
    // The host table is built from both marker pages before any erase.
    for (int i = 0; i < 32; i++) begin
      op(NBBM_OP_READ, i / 2, i % 2, 2048, 0);
      `CMP("marker", want(i / 2, i % 2, 2048), rsp_data)
      bbt[i / 2] = bbt[i / 2] | (rsp_data != 8'hFF);
    end
    `CMP("bbt", BAD & 16'hFFFE, bbt)
    op(NBBM_OP_READ, 2, 5, 7, 0);
    `CMP("iso_data", 8'hFF, rsp_data)
    op(NBBM_OP_PROG, 5, 0, 0, 0);
    `CMP("iso_prog", 1'b1, rsp_fail)
    op(NBBM_OP_ERASE, 2, 0, 0, 0);
    `CMP("iso_erase", 1'b1, rsp_fail)
    wiped[2] = 1;
    op(NBBM_OP_READ, 2, 1, 2048, 0);
    `CMP("wiped_mark", 8'hFF, rsp_data)
    for (int i = 0; i < 40; i++) begin
      do b = $unsigned($random(seed)) % 16; while (bbt[b]);
      o = nbbm_op_t'($unsigned($random(seed)) % 3);
      // Failures spare block zero and are capped so spares never run out.
      f = ($unsigned($random(seed)) % 4 == 0) && o != NBBM_OP_READ &&
          b != 0 && retired < 4;
      op(o, b, pg[b], $unsigned($random(seed)) % 2112, f);
      // The array model injects no bit errors, so the read byte
      // must equal the expected pattern exactly.
      if (o == NBBM_OP_READ)
        `CMP("rd_data", want(b, pg[b], req_col), rsp_data)
      else
        `CMP("status", f, rsp_fail)
      if (o == NBBM_OP_PROG && !f) pg[b] = (pg[b] + 1) % 64;
      if (o == NBBM_OP_ERASE && !f) pg[b] = 0;
      if (f) begin
        // Move the earlier pages to a fresh block, then rewrite the
        // page of a failed program there, and retire the original.
        n = (o == NBBM_OP_PROG) ? pg[b] : 0;
        r = 1;
        while (bbt[r] || r == b) r++;
        op(NBBM_OP_ERASE, r, 0, 0, 0);
        `CMP("spare_erase", 1'b0, rsp_fail)
        for (int p = 0; p < n; p++) begin
          op(NBBM_OP_READ, b, p, 0, 0);
          `CMP("copy_src", want(b, p, 0), rsp_data)
          op(NBBM_OP_PROG, r, p, 0, 0);
        end
        if (o == NBBM_OP_PROG) op(NBBM_OP_PROG, r, n, 0, 0);
        pg[r] = (o == NBBM_OP_PROG) ? (n + 1) % 64 : 0;
        bbt[b] = 1;
        retired++;
      end
    end
    end_of_test();
  end
endmodule // nbbm_top_test
`default_nettype wire
